// ---- adcsq_convclk.sv ----
// Conversion clock source: internal divider or external pin, as a falling-edge pulse.
`timescale 1ns/10ps
module adcsq_convclk
  import adcsq_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Control from the sequencer.
  input wire logic i_use_int,
  input wire logic i_run,
  input wire logic i_restart,
  // External conversion clock pin.
  input wire logic i_ext_clk,
  // One-cycle pulse per conversion-clock falling edge.
  output logic o_fall
);

  // Registered state and its next value.
  adcsq_clk_s st_ff;
  adcsq_clk_s nxt_st;

  // Next-state logic for both clock sources.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ext_prev = i_ext_clk;
    nxt_st.fall = 1'b0;
    if (!i_run || i_restart) begin
      // The divider restarts high so the first falling edge lands a half period after a write.
      nxt_st.cnt = 5'h00;
      nxt_st.phase = 1'b1;
    end else if (i_use_int) begin
      // Internal divider toggles its phase every half period.
      if (st_ff.cnt == INT_HALF_CYC - 5'h01) begin
        nxt_st.cnt = 5'h00;
        nxt_st.phase = ~st_ff.phase;
        nxt_st.fall = st_ff.phase;
      end else begin
        nxt_st.cnt = st_ff.cnt + 5'h01;
      end
    end else begin
      // External clock pin is synchronous; a high-to-low step is a falling edge.
      nxt_st.fall = st_ff.ext_prev & ~i_ext_clk;
    end
  end

  // State register.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_ff <= CLK_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // The edge pulse comes straight from its flip-flop.
  assign o_fall = st_ff.fall;

endmodule

// ---- adcsq_host.sv ----
// Host partner model: parallel-bus write and read cycles plus the external conversion clock.
`timescale 1ns/10ps
module adcsq_host #(
  parameter int EXT_HALF = 6
) (
  // Clock.
  input wire logic i_clk,
  // Run request for the external conversion clock.
  input wire logic i_ext_en,
  // Parallel bus strobes, active low, and data.
  output logic o_cs_n,
  output logic o_wr_n,
  output logic o_rd_n,
  output logic [7:0] o_data,
  // External conversion clock.
  output logic o_ext_clk
);
  int half_cnt; // System clocks spent in the current half period.

  // Idle bus and a clock parked high.
  initial begin
    o_cs_n = 1'b1;
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
    o_data = 8'h00;
    o_ext_clk = 1'b1;
    half_cnt = 0;
  end

  // The clock stands high outside frames so no stray falling edge is seen.
  always @(posedge i_clk) begin
    #1;
    if (!i_ext_en) begin
      o_ext_clk = 1'b1;
      half_cnt = 0;
    end else if (half_cnt == EXT_HALF - 1) begin
      o_ext_clk = ~o_ext_clk;
      half_cnt = 0;
    end else begin
      half_cnt = half_cnt + 1;
    end
  end

  // One write: the strobe is low a full cycle, data stays past its rising step, then the bus is let go.
  task automatic write_byte(input logic [7:0] b);
    @(posedge i_clk);
    #1;
    o_cs_n = 1'b0;
    o_wr_n = 1'b0;
    o_data = b;
    @(posedge i_clk);
    #1;
    o_wr_n = 1'b1;
    @(posedge i_clk);
    #1;
    o_cs_n = 1'b1;
    o_data = ~b; // Released lines show no stale byte.
  endtask

  // One read: the strobe falls with chip select low for one cycle.
  task automatic read_pulse();
    @(posedge i_clk);
    #1;
    o_cs_n = 1'b0;
    o_rd_n = 1'b0;
    @(posedge i_clk);
    #1;
    o_rd_n = 1'b1;
    o_cs_n = 1'b1;
  endtask
endmodule

// ---- adcsq_pkg.sv ----
// Shared types, constants and state layouts for the converter control sequencer.
// How it works
// - Codes 00/01 power down, keep clock source.
// - Codes 10/11 run on internal/external clock.
// - Bit 5 picks internal or external acquisition.
// - Bit 4 picks pair or single-ended input.
// - Bit 3 picks bipolar or unipolar range.
// - Single-ended: codes 0-5 route channel, common negative.
// - Pair mode: pairs 0/1, 2/3, 4/5 routed.
// - Tracking starts on write strobe rising edge.
// - External acquisition holds on next write edge.
// - Internal acquisition holds on fourth falling edge.
// - Internal acquisition then starts conversion automatically.
// - Conversion lasts exactly thirteen conversion clocks.
// - Write during conversion aborts, starts new acquisition.
// - External acquisition uses two writes, bit set then cleared.
// - Second write may change the power bits.
// - Write edge with select low captures byte.
// - Done flag low at result, high on read/write.
// - Result straight binary unipolar, two's complement bipolar.
// - Power-up defaults to external conversion clock.
package adcsq_pkg;

  // Control byte fields, most significant bit first.
  typedef struct packed {
    logic power_sel_hi;
    logic power_sel_lo;
    logic acquisition_timing_sel;
    logic single_or_pair_sel;
    logic polarity_sel;
    logic chan_sel_2;
    logic chan_sel_1;
    logic chan_sel_0;
  } adcsq_ctl_s;

  // Power field codes, also used as the reported power mode.
  localparam logic [1:0] PWR_FULL_DOWN = 2'h0;
  localparam logic [1:0] PWR_STANDBY = 2'h1;
  localparam logic [1:0] PWR_NORM_INT = 2'h2;
  localparam logic [1:0] PWR_NORM_EXT = 2'h3;

  // Power-up control byte: normal operation on the external clock.
  localparam adcsq_ctl_s CTL_RESET = 8'hC0;

  // Sizes of the result and of the channel address.
  localparam int RESULT_W = 12;
  localparam logic [11:0] RESULT_MSB = 12'h800;
  localparam logic [11:0] RESULT_ZERO = 12'h000;
  localparam logic [2:0] CHAN_ZERO = 3'h0;
  localparam logic [2:0] CHAN_PAIR_FLIP = 3'h1;

  // Internal conversion clock: half period and its count of system clocks, rounded up.
  localparam int CLK_PERIOD_PS = 8000;
  localparam int INT_CLK_HALF_NS = 140;
  localparam logic [4:0] INT_HALF_CYC = 5'((INT_CLK_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  // Acquisition and conversion lengths in conversion-clock falling edges.
  localparam logic [3:0] ACQ_FALL_EDGES = 4'h4;
  localparam logic [3:0] CONV_CYCLES = 4'hD;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACQ_INT,
    ST_ACQ_EXT,
    ST_CONV
  } adcsq_state_e;

  // Whole state of the sequencer.
  typedef struct packed {
    adcsq_state_e state;
    logic wr_prev;
    logic rd_prev;
    adcsq_ctl_s ctl;
    logic use_int;
    logic int_n;
    logic track;
    logic [1:0] pwr;
    logic [3:0] cnt;
    logic [11:0] dac;
    logic [11:0] result;
    logic [2:0] pos_chan;
    logic [2:0] neg_chan;
    logic neg_com;
  } adcsq_seq_s;

  // Reset value of the sequencer state.
  localparam adcsq_seq_s SEQ_RESET = '{state: ST_IDLE, wr_prev: 1'b1, rd_prev: 1'b1, ctl: CTL_RESET,
    use_int: 1'b0, int_n: 1'b1, track: 1'b0, pwr: PWR_NORM_EXT, cnt: 4'h0, dac: 12'h000,
    result: 12'h000, pos_chan: 3'h0, neg_chan: 3'h0, neg_com: 1'b1};

  // Whole state of the conversion clock source.
  typedef struct packed {
    logic ext_prev;
    logic phase;
    logic [4:0] cnt;
    logic fall;
  } adcsq_clk_s;

  // Reset value of the clock source state.
  localparam adcsq_clk_s CLK_RESET = '{ext_prev: 1'b0, phase: 1'b1, cnt: 5'h00, fall: 1'b0};

endpackage

// ---- adcsq_seq.sv ----
// Control byte decoder and track, hold and conversion sequencer of the converter.
`timescale 1ns/10ps
module adcsq_seq
  import adcsq_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Parallel host interface strobes, active low.
  input wire logic i_cs_n,
  input wire logic i_wr_n,
  input wire logic i_rd_n,
  // Low eight data lines carrying the control byte.
  input wire logic [7:0] i_data,
  // External conversion clock pin.
  input wire logic i_ext_clk,
  // Comparator answer: high when the input is at or above the trial code.
  input wire logic i_cmp,
  // Done flag, active low.
  output logic o_int_n,
  // Track/hold and converter status.
  output logic o_track,
  output logic o_converting,
  output logic o_clk_internal,
  output logic [1:0] o_power_mode,
  // Input routing.
  output logic [2:0] o_pos_chan,
  output logic [2:0] o_neg_chan,
  output logic o_neg_com,
  output logic o_unipolar,
  // Trial code to the capacitive DAC and finished result.
  output logic [11:0] o_dac_code,
  output logic [11:0] o_result
);

  // Registered state and its next value.
  adcsq_seq_s st_ff;
  adcsq_seq_s nxt_st;

  // Decoded host events and the incoming control byte.
  logic wr_evt;
  logic rd_evt;
  adcsq_ctl_s ctl_in;
  logic [11:0] trial_mask;
  logic conv_fall;

  // Routes the positive and negative sampling inputs for a control byte.
  function automatic logic [6:0] route_inputs(input adcsq_ctl_s c);
    logic [2:0] chan;
    chan = {c.chan_sel_2, c.chan_sel_1, c.chan_sel_0};
    if (c.single_or_pair_sel) begin
      // Single-ended: selected channel against the common reference input.
      route_inputs = {1'b1, CHAN_ZERO, chan};
    end else begin
      // Pair mode: the partner of the pair is negative.
      route_inputs = {1'b0, chan ^ CHAN_PAIR_FLIP, chan};
    end
  endfunction

  // Formats a finished code as straight binary or two's complement.
  function automatic logic [11:0] format_result(input logic [11:0] code, input logic unipolar);
    if (unipolar) begin
      format_result = code;
    end else begin
      // Offset binary becomes two's complement by flipping the top bit.
      format_result = code ^ RESULT_MSB;
    end
  endfunction

  // Conversion clock source.
  adcsq_convclk u_convclk (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_use_int(st_ff.use_int),
    .i_run(st_ff.state != ST_IDLE),
    .i_restart(wr_evt),
    .i_ext_clk(i_ext_clk),
    .o_fall(conv_fall)
  );

  // Host events: write on the strobe rising edge, read on the read falling edge, both under select.
  always_comb begin
    wr_evt = !i_cs_n && !st_ff.wr_prev && i_wr_n;
    rd_evt = !i_cs_n && st_ff.rd_prev && !i_rd_n;
    ctl_in = adcsq_ctl_s'(i_data);
    trial_mask = RESULT_MSB >> st_ff.cnt;
  end

  // Next-state logic of the sequencer.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.wr_prev = i_wr_n;
    nxt_st.rd_prev = i_rd_n;
    // A read releases the done flag; a completion in the same cycle is applied later and wins.
    if (rd_evt) begin
      nxt_st.int_n = 1'b1;
    end
    if (wr_evt) begin
      // Every write is accepted, even while powered down, and wakes the converter.
      nxt_st.int_n = 1'b1;
      nxt_st.ctl = ctl_in;
      if (ctl_in.power_sel_hi) begin
        // Normal codes choose the clock source.
        nxt_st.use_int = !ctl_in.power_sel_lo;
      end
      // Power-down codes leave the clock source as it was.
      nxt_st.pwr = {1'b1, !nxt_st.use_int};
      if (st_ff.state == ST_ACQ_EXT && !ctl_in.acquisition_timing_sel) begin
        // Second write of an external acquisition: hold now and convert.
        nxt_st.state = ST_CONV;
        nxt_st.track = 1'b0;
        nxt_st.cnt = 4'h0;
        nxt_st.dac = RESULT_MSB;
      end else begin
        // Any other write, including one during a conversion, starts a fresh acquisition.
        {nxt_st.neg_com, nxt_st.neg_chan, nxt_st.pos_chan} = route_inputs(ctl_in);
        nxt_st.track = 1'b1;
        nxt_st.cnt = 4'h0;
        nxt_st.dac = RESULT_ZERO;
        if (ctl_in.acquisition_timing_sel) begin
          // Open-ended acquisition until the host writes again.
          nxt_st.state = ST_ACQ_EXT;
        end else begin
          // Internally timed acquisition.
          nxt_st.state = ST_ACQ_INT;
        end
      end
    end else begin
      case (st_ff.state)
        ST_ACQ_INT: begin
          // Count falling edges; the fourth one ends tracking and starts conversion.
          if (conv_fall) begin
            if (st_ff.cnt == ACQ_FALL_EDGES - 4'h1) begin
              nxt_st.state = ST_CONV;
              nxt_st.track = 1'b0;
              nxt_st.cnt = 4'h0;
              nxt_st.dac = RESULT_MSB;
            end else begin
              nxt_st.cnt = st_ff.cnt + 4'h1;
            end
          end
        end
        ST_ACQ_EXT: begin
          // Tracking continues until the second write.
          nxt_st.track = 1'b1;
        end
        ST_CONV: begin
          // Twelve edges decide one bit each, the thirteenth closes the conversion.
          if (conv_fall) begin
            if (st_ff.cnt == CONV_CYCLES - 4'h1) begin
              nxt_st.state = ST_IDLE;
              nxt_st.result = format_result(st_ff.dac, st_ff.ctl.polarity_sel);
              nxt_st.int_n = 1'b0;
              // A power-down code in the last byte takes effect once the result is in.
              if (st_ff.ctl.power_sel_hi) begin
                nxt_st.pwr = {1'b1, !st_ff.use_int};
              end else begin
                nxt_st.pwr = {1'b0, st_ff.ctl.power_sel_lo};
              end
            end else begin
              // Keep or drop the bit on trial and put the next lower bit on trial.
              nxt_st.dac = (st_ff.dac & ~(i_cmp ? RESULT_ZERO : trial_mask)) | (trial_mask >> 1);
              nxt_st.cnt = st_ff.cnt + 4'h1;
            end
          end
        end
        default: begin
          // Idle: nothing moves until the next write.
          nxt_st.track = 1'b0;
        end
      endcase
    end
  end

  // State register; power-up state is normal operation on the external clock.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_ff <= SEQ_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs come straight from the state register.
  assign o_int_n = st_ff.int_n;
  assign o_track = st_ff.track;
  assign o_converting = (st_ff.state == ST_CONV);
  assign o_clk_internal = st_ff.use_int;
  assign o_power_mode = st_ff.pwr;
  assign o_pos_chan = st_ff.pos_chan;
  assign o_neg_chan = st_ff.neg_chan;
  assign o_neg_com = st_ff.neg_com;
  assign o_unipolar = st_ff.ctl.polarity_sel;
  assign o_dac_code = st_ff.dac;
  assign o_result = st_ff.result;

  // Helper: counts conversion-clock falling edges seen while converting.
  logic [4:0] chk_edges_ff;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      chk_edges_ff <= 5'h00;
    end else if (st_ff.state != ST_CONV) begin
      chk_edges_ff <= 5'h00;
    end else if (conv_fall) begin
      chk_edges_ff <= chk_edges_ff + 5'h01;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  // Power-down codes keep the clock source.
  a_clk_src_keep: assert property (wr_evt && !i_data[7] |=> o_clk_internal == $past(o_clk_internal))
    else $error("clock source changed on a power-down code");

  // Normal codes select the clock source from bit 6.
  a_clk_src_sel: assert property (wr_evt && i_data[7] |=> o_clk_internal == !$past(i_data[6]))
    else $error("clock source does not follow the normal code");

  // Single-ended routing uses the common input as negative.
  a_route_single: assert property (wr_evt && i_data[4] && !(st_ff.state == ST_ACQ_EXT && !i_data[5])
      |=> o_neg_com && o_pos_chan == $past(i_data[2:0]))
    else $error("single-ended routing wrong");

  // Pair routing makes the partner channel negative.
  a_route_pair: assert property (wr_evt && !i_data[4] && !(st_ff.state == ST_ACQ_EXT && !i_data[5])
      |=> !o_neg_com && o_neg_chan == ($past(i_data[2:0]) ^ 3'h1))
    else $error("pair routing wrong");

  // A starting write puts the stage into tracking on the next cycle.
  a_track_start: assert property (wr_evt && !(st_ff.state == ST_ACQ_EXT && !i_data[5]) |=> o_track)
    else $error("tracking did not start on write");

  // The second write of an external acquisition holds and converts.
  a_ext_hold: assert property (wr_evt && st_ff.state == ST_ACQ_EXT && !i_data[5]
      |=> !o_track && o_converting)
    else $error("external acquisition did not hold on second write");

  // Internal acquisition holds on its fourth falling edge.
  a_int_hold: assert property (st_ff.state == ST_ACQ_INT && conv_fall && st_ff.cnt == 4'h3 && !wr_evt
      |=> !o_track && o_converting)
    else $error("internal acquisition did not hold on fourth edge");

  // A conversion ends with exactly thirteen falling edges counted.
  a_conv_length: assert property (o_converting && !wr_evt && !nxt_st.int_n
      |-> chk_edges_ff == 5'h0C && conv_fall)
    else $error("conversion length is not thirteen clocks");

  // A write during conversion aborts it in favour of a new acquisition.
  a_conv_abort: assert property (o_converting && wr_evt |=> !o_converting && o_track)
    else $error("write did not abort conversion");

  // The done flag falls only when a conversion stores its result.
  a_done_flag: assert property ($fell(o_int_n) |-> $past(o_converting))
    else $error("done flag fell outside a conversion");

  // Bipolar results carry the inverted top trial bit.
  a_result_fmt: assert property ($fell(o_int_n)
      |-> o_result[11] == ($past(st_ff.dac[11]) ^ !o_unipolar))
    else $error("result format wrong");

  // The stored polarity follows bit 3 of every byte.
  a_polarity_sel: assert property (wr_evt |=> o_unipolar == $past(i_data[3]))
    else $error("polarity does not follow bit 3");

  // A starting write picks external or internal acquisition from bit 5.
  a_acq_mode: assert property (wr_evt && !(st_ff.state == ST_ACQ_EXT && !i_data[5])
      |=> (st_ff.state == ST_ACQ_EXT) == $past(i_data[5]))
    else $error("acquisition mode does not follow bit 5");

  // External acquisition keeps tracking until the host writes again.
  a_ext_wait: assert property (st_ff.state == ST_ACQ_EXT && !wr_evt |=> o_track && !o_converting)
    else $error("external acquisition ended without a write");

  // Internal acquisition keeps tracking until its fourth falling edge.
  a_int_wait: assert property (st_ff.state == ST_ACQ_INT && !wr_evt && !(conv_fall && st_ff.cnt == 4'h3)
      |=> o_track && !o_converting)
    else $error("internal acquisition ended early");

  // A write always releases the done flag.
  a_done_write: assert property (wr_evt |=> o_int_n)
    else $error("done flag not released by a write");

  // A read releases the done flag unless a result lands in the same cycle.
  a_done_read: assert property (rd_evt && !(!wr_evt && o_converting && conv_fall && st_ff.cnt == 4'hC)
      |=> o_int_n)
    else $error("done flag not released by a read");

  // Completion reports the power mode of the last byte.
  a_power_done: assert property ($fell(o_int_n)
      |-> o_power_mode == (st_ff.ctl.power_sel_hi ? {1'b1, !o_clk_internal} : {1'b0, st_ff.ctl.power_sel_lo}))
    else $error("power mode after completion wrong");

  // A normal code wakes the converter into the chosen normal mode.
  a_wake_mode: assert property (wr_evt && i_data[7] |=> o_power_mode == {1'b1, $past(i_data[6])})
    else $error("normal code did not wake the converter");

  // Every conversion starts with the top bit on trial.
  a_conv_first: assert property ($rose(o_converting) |-> o_dac_code == RESULT_MSB)
    else $error("conversion did not start on the top bit");

  // The stage holds for the whole conversion.
  a_conv_hold: assert property (o_converting |-> !o_track)
    else $error("stage tracks during conversion");

  // The second write of an external acquisition leaves the routing as it was.
  a_route_kept: assert property (wr_evt && st_ff.state == ST_ACQ_EXT && !i_data[5]
      |=> $stable(o_pos_chan) && $stable(o_neg_chan) && $stable(o_neg_com))
    else $error("routing changed on the second write");

endmodule

// ---- test_adc_control_byte_sequencer.sv ----
// Self-checking testbench of the converter control sequencer.
`timescale 1ns/10ps
module test_adc_control_byte_sequencer
  import adcsq_pkg::*;
;
  logic clk, arst_n, cmp, ext_en, cs_n, wr_n, rd_n, ext_clk; // Bench-driven lines.
  logic [7:0] data; // Bus data from the host.
  logic int_n, track, conv_on, clk_int, neg_com, unip; // Status outputs.
  logic [1:0] pm; // Reported power mode.
  logic [2:0] pos, neg; // Routing outputs.
  logic [11:0] dac, res; // Trial code and result.
  int err_total, n_tests, cyc; // Counters.

  adcsq_host #(.EXT_HALF(6)) host (.i_clk(clk), .i_ext_en(ext_en), .o_cs_n(cs_n), .o_wr_n(wr_n),
    .o_rd_n(rd_n), .o_data(data), .o_ext_clk(ext_clk));

  adcsq_seq dut (.i_clk(clk), .i_arst_n(arst_n), .i_cs_n(cs_n), .i_wr_n(wr_n), .i_rd_n(rd_n),
    .i_data(data), .i_ext_clk(ext_clk), .i_cmp(cmp), .o_int_n(int_n), .o_track(track),
    .o_converting(conv_on), .o_clk_internal(clk_int), .o_power_mode(pm), .o_pos_chan(pos),
    .o_neg_chan(neg), .o_neg_com(neg_com), .o_unipolar(unip), .o_dac_code(dac), .o_result(res));

  // Clock of 8 ns.
  always #4 clk = ~clk;

  // Cuts a hang short.
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      err_total = err_total + 1;
      report_and_stop();
    end
  end

  // Compares one value and counts the result.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Waits whole cycles, landing just after the edge.
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask

  // Writes a byte and lets its answer land.
  task automatic wr(input logic [7:0] b);
    host.write_byte(b);
    tick(1);
  endtask

  // Output levels straight after reset.
  task automatic reset_check();
    chk(int_n, 1);
    chk(track, 0);
    chk(conv_on, 0);
    chk(clk_int, 0);
    chk(pm, PWR_NORM_EXT);
    chk(neg_com, 1);
    chk(res, RESULT_ZERO);
  endtask

  // Every defined channel code in both input modes, polarity alternating.
  task automatic routing_scan();
    logic [2:0] c;
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 6; k++) begin
        c = 3'(k);
        wr({2'h3, 1'b0, s[0], k[0], c}); // Only codes 0 to 5.
        chk(track, 1);
        chk(unip, k[0]);
        chk(pos, c);
        chk(neg_com, s[0]);
        chk(neg, s[0] ? CHAN_ZERO : (c ^ CHAN_PAIR_FLIP));
      end
    end
  endtask

  // Times the conversion, then checks flag, result, mode and the read that clears the flag.
  task automatic finish_conv(input logic ic, input logic [11:0] r, input logic [1:0] p);
    int n;
    int f;
    logic pv;
    #1;
    pv = ext_clk;
    chk(conv_on, 1);
    chk(dac, RESULT_MSB);
    n = 0;
    f = 0;
    while (conv_on === 1'b1 && n < 1000) begin
      @(posedge clk);
      #2;
      f = f + int'(pv & ~ext_clk);
      pv = ext_clk;
      n = n + 1;
    end
    chk(ic ? n : f, ic ? 13 * 2 * int'(INT_HALF_CYC) : 13);
    chk(int_n, 0);
    chk(res, r);
    chk(pm, p);
    chk(clk_int, ic);
    host.read_pulse();
    tick(1);
    ext_en <= 1'b0;
    chk(int_n, 1);
  endtask

  // Internally timed acquisition: hold comes on the fourth clock fall, then the conversion.
  task automatic conv(input logic [7:0] b, input logic c, input logic ic, input logic [11:0] r,
    input logic [1:0] p);
    int n;
    int f;
    logic pv;
    cmp <= c;
    wr(b);
    chk(track, 1);
    chk(conv_on, 0);
    chk(int_n, 1);
    ext_en <= ~ic;
    n = 0;
    f = 0;
    pv = 1'b1;
    while (track === 1'b1 && n < 400) begin
      @(posedge clk);
      #2;
      f = f + int'(pv & ~ext_clk);
      pv = ext_clk;
      n = n + 1;
    end
    if (!ic) begin
      chk(f, 4);
    end
    finish_conv(ic, r, p);
  endtask

  // Host-terminated acquisition: clock falls do not end it, the second write does.
  task automatic ext_acq();
    cmp <= 1'b0;
    wr(8'hF9); // Open-ended acquisition on channel 1.
    chk(track, 1);
    ext_en <= 1'b1;
    tick(60);
    chk(track, 1);
    ext_en <= 1'b0;
    tick(2);
    wr(8'h59); // Same address and setup, standby requested.
    chk(track, 0);
    ext_en <= 1'b1;
    finish_conv(1'b0, RESULT_ZERO, PWR_STANDBY);
  endtask

  // A write in mid-conversion abandons it and starts a fresh acquisition.
  task automatic abort_run();
    int n;
    cmp <= 1'b1;
    wr(8'hD8);
    ext_en <= 1'b1;
    n = 0;
    while (conv_on !== 1'b1 && n < 200) begin
      tick(1);
      n = n + 1;
    end
    tick(20);
    ext_en <= 1'b0;
    conv(8'hD8, 1'b1, 1'b0, 12'hFFF, PWR_NORM_EXT);
  endtask

  // Main sequence.
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    cmp = 1'b0;
    ext_en = 1'b0;
    err_total = 0;
    n_tests = 0;
    cyc = 0;
    repeat (12) @(posedge clk);
    #1;
    arst_n = 1'b1;
    reset_check();
    routing_scan();
    conv(8'hD8, 1'b1, 1'b0, 12'hFFF, PWR_NORM_EXT);
    ext_acq();
    conv(8'h90, 1'b1, 1'b1, 12'h7FF, PWR_NORM_INT);
    conv(8'h10, 1'b0, 1'b1, RESULT_MSB, PWR_FULL_DOWN);
    abort_run();
    report_and_stop();
  end
endmodule
